// File: design/dmt_tick_select.v
// prescaler tap selection: one-cycle count tick for a counter half
// assumes the prescaler counts up by one on every clock
`include "dmt_defines.vh"
module dmt_tick_select (
  input wire clk,
  input wire rst_n,
  input wire [`DMT_PRE_W-1:0] prescale,
  input wire [1:0] sel,
  output wire tick
);
  // ****************************************
  // tap edge detect
  // ****************************************
  reg [`DMT_PRE_W-1:0] prescale_q;
  reg bit_now;
  reg bit_old;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_q <= {`DMT_PRE_W{1'b0}};
    end else begin
      prescale_q <= prescale;
    end
  end
  always @* begin
    bit_now = prescale[`DMT_TAP_D32];
    bit_old = prescale_q[`DMT_TAP_D32];
    case (sel)
      `DMT_SEL_D32: begin
        bit_now = prescale[`DMT_TAP_D32];
        bit_old = prescale_q[`DMT_TAP_D32];
      end
      `DMT_SEL_D16: begin
        bit_now = prescale[`DMT_TAP_D16];
        bit_old = prescale_q[`DMT_TAP_D16];
      end
      `DMT_SEL_D4: begin
        bit_now = prescale[`DMT_TAP_D4];
        bit_old = prescale_q[`DMT_TAP_D4];
      end
      default: begin
        bit_now = prescale[`DMT_TAP_D2];
        bit_old = prescale_q[`DMT_TAP_D2];
      end
    endcase
  end
  // falling edge of a tap bit gives one tick per full period
  assign tick = bit_old & ~bit_now;
endmodule

// File: design/dmt_timer.v
// dual mode compare timer: counters, compares, control and status
// assumes one-cycle rd/wr strobes from the cpu and a synchronous event pin
`include "dmt_defines.vh"
module dmt_timer (
  input wire clk,
  input wire rst_n,
  input wire standby,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire event_input_pin,
  input wire event_edge_select,
  output reg upper_toggle_output_pin,
  output reg lower_toggle_output_pin,
  output reg upper_overflow_irq,
  output reg lower_overflow_irq,
  output reg upper_compare_irq,
  output reg lower_compare_irq
);
  // ****************************************
  // registers
  // ****************************************
  reg [7:0] timer_control;
  reg [7:0] timer_control_status;
  reg [7:0] upper_counter;
  reg [7:0] lower_counter;
  reg [7:0] upper_compare;
  reg [7:0] lower_compare;
  reg [`DMT_PRE_W-1:0] prescale;
  reg event_q;
  reg event_armed;
  reg [3:0] flag_seen;
  reg [7:0] next_status;
  wire wr_ctrl = wr & (addr == `DMT_ADDR_CTRL);
  wire wr_csr = wr & (addr == `DMT_ADDR_CSR);
  wire wr_ucnt = wr & (addr == `DMT_ADDR_UCNT);
  wire wr_lcnt = wr & (addr == `DMT_ADDR_LCNT);
  wire wr_ucmp = wr & (addr == `DMT_ADDR_UCMP);
  wire wr_lcmp = wr & (addr == `DMT_ADDR_LCMP);
  wire rd_csr = rd & (addr == `DMT_ADDR_CSR);
  wire wide_mode = ~timer_control[`DMT_B_USEL_TOP];
  // ****************************************
  // count ticks
  // ****************************************
  wire upper_pre_tick;
  wire lower_pre_tick;
  dmt_tick_select u_upper_sel (
    .clk(clk),
    .rst_n(rst_n),
    .prescale(prescale),
    .sel(timer_control[`DMT_B_USEL_MID:`DMT_B_USEL_LOW]),
    .tick(upper_pre_tick)
  );
  dmt_tick_select u_lower_sel (
    .clk(clk),
    .rst_n(rst_n),
    .prescale(prescale),
    .sel(timer_control[`DMT_B_LSEL_MID:`DMT_B_LSEL_LOW]),
    .tick(lower_pre_tick)
  );
  // edge select 1 counts rising edges, 0 falling
  // no edge until the pin was sampled once: a high pin at reset is no rise
  wire event_edge = event_armed & (event_edge_select ?
    (event_input_pin & ~event_q) : (~event_input_pin & event_q));
  wire lower_tick = timer_control[`DMT_B_LSEL_TOP] ? lower_pre_tick :
    event_edge;
  wire lower_wrap = lower_tick & (lower_counter == `DMT_BYTE_ONES);
  // cascade: upper counts lower wraps; mid and low select ignored
  wire upper_tick = wide_mode ? lower_wrap : upper_pre_tick;
  wire upper_wrap = upper_tick & (upper_counter == `DMT_BYTE_ONES);
  // match fires when the counter leaves the matching value
  wire wide_match = (upper_counter == upper_compare) &
    (lower_counter == lower_compare);
  wire upper_match = wide_mode ? (wide_match & lower_tick) :
    ((upper_counter == upper_compare) & upper_tick);
  wire lower_match = (lower_counter == lower_compare) & lower_tick;
  wire upper_clear = timer_control_status[`DMT_B_UCLR] & upper_match;
  wire lower_clear = wide_mode ? upper_clear :
    (timer_control_status[`DMT_B_LCLR] & lower_match);
  // ****************************************
  // counters and prescaler
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= {`DMT_PRE_W{1'b0}};
      event_q <= 1'b0;
      event_armed <= 1'b0;
      upper_counter <= `DMT_BYTE_ZERO;
      lower_counter <= `DMT_BYTE_ZERO;
      upper_compare <= `DMT_CMP_RESET;
      lower_compare <= `DMT_CMP_RESET;
    end else begin
      prescale <= prescale + `DMT_PRE_ONE;
      event_q <= event_input_pin;
      event_armed <= 1'b1;
      if (wr_ucmp) begin
        upper_compare <= wdata;
      end
      if (wr_lcmp) begin
        lower_compare <= wdata;
      end
      // in 16-bit mode both halves clear on a wide match
      if (wr_ucnt) begin
        upper_counter <= wdata;
      end else if (upper_clear) begin
        upper_counter <= `DMT_BYTE_ZERO;
      end else if (upper_tick) begin
        upper_counter <= upper_counter + 8'h01;
      end
      if (wr_lcnt) begin
        lower_counter <= wdata;
      end else if (lower_clear) begin
        lower_counter <= `DMT_BYTE_ZERO;
      end else if (lower_tick) begin
        lower_counter <= lower_counter + 8'h01;
      end
    end
  end
  // ****************************************
  // control register and toggle outputs
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control <= `DMT_CTRL_RESET;
      upper_toggle_output_pin <= 1'b0;
      lower_toggle_output_pin <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        timer_control <= wdata;
      end
      // a write wins over a toggle in the same cycle
      if (wr_ctrl) begin
        upper_toggle_output_pin <= wdata[`DMT_B_UTOG];
      end else if (upper_match) begin
        upper_toggle_output_pin <= ~upper_toggle_output_pin;
      end
      if (wr_ctrl) begin
        lower_toggle_output_pin <= wdata[`DMT_B_LTOG];
      end else if (lower_match & ~wide_mode) begin
        lower_toggle_output_pin <= ~lower_toggle_output_pin;
      end
    end
  end
  // ****************************************
  // status register
  // ****************************************
  // clear_bit: a 0 written after the flag was read as 1
  function clear_bit;
    input seen;
    input wbit;
    begin
      clear_bit = seen & ~wbit;
    end
  endfunction
  always @* begin
    next_status = timer_control_status;
    if (wr_csr) begin
      next_status[`DMT_B_UOVIE] = wdata[`DMT_B_UOVIE];
      next_status[`DMT_B_UCLR] = wdata[`DMT_B_UCLR];
      next_status[`DMT_B_LOVIE] = wdata[`DMT_B_LOVIE];
      next_status[`DMT_B_LCLR] = wdata[`DMT_B_LCLR];
      // writing 1 leaves a flag alone; software never sets one
      if (clear_bit(flag_seen[3], wdata[`DMT_B_UOVF]))
        next_status[`DMT_B_UOVF] = 1'b0;
      if (clear_bit(flag_seen[2], wdata[`DMT_B_UCMF]))
        next_status[`DMT_B_UCMF] = 1'b0;
      if (clear_bit(flag_seen[1], wdata[`DMT_B_LOVF]))
        next_status[`DMT_B_LOVF] = 1'b0;
      if (clear_bit(flag_seen[0], wdata[`DMT_B_LCMF]))
        next_status[`DMT_B_LCMF] = 1'b0;
    end
    // hardware sets last so they win over a clearing write
    if (upper_wrap)
      next_status[`DMT_B_UOVF] = 1'b1;
    if (upper_match)
      next_status[`DMT_B_UCMF] = 1'b1;
    if (lower_wrap & ~wide_mode)
      next_status[`DMT_B_LOVF] = 1'b1;
    if (lower_match & ~wide_mode)
      next_status[`DMT_B_LCMF] = 1'b1;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_status <= `DMT_CSR_RESET;
      flag_seen <= 4'h0;
    end else if (standby) begin
      timer_control_status <= `DMT_CSR_RESET;
      flag_seen <= 4'h0;
    end else begin
      timer_control_status <= next_status;
      if (rd_csr) begin
        flag_seen <= {timer_control_status[`DMT_B_UOVF],
          timer_control_status[`DMT_B_UCMF],
          timer_control_status[`DMT_B_LOVF],
          timer_control_status[`DMT_B_LCMF]};
      end else if (wr_csr) begin
        flag_seen <= 4'h0;
      end
    end
  end
  // ****************************************
  // read data and interrupt requests
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `DMT_BYTE_ZERO;
      upper_overflow_irq <= 1'b0;
      lower_overflow_irq <= 1'b0;
      upper_compare_irq <= 1'b0;
      lower_compare_irq <= 1'b0;
    end else begin
      // control register is write only and reads as ones
      if (addr == `DMT_ADDR_CSR) begin
        rdata <= timer_control_status;
      end else if (addr == `DMT_ADDR_UCNT) begin
        rdata <= upper_counter;
      end else if (addr == `DMT_ADDR_LCNT) begin
        rdata <= lower_counter;
      end else if (addr == `DMT_ADDR_UCMP) begin
        rdata <= upper_compare;
      end else if (addr == `DMT_ADDR_LCMP) begin
        rdata <= lower_compare;
      end else begin
        rdata <= `DMT_BYTE_ONES;
      end
      upper_overflow_irq <= timer_control_status[`DMT_B_UOVF] &
        timer_control_status[`DMT_B_UOVIE];
      lower_overflow_irq <= timer_control_status[`DMT_B_LOVF] &
        timer_control_status[`DMT_B_LOVIE];
      upper_compare_irq <= timer_control_status[`DMT_B_UCMF];
      lower_compare_irq <= timer_control_status[`DMT_B_LCMF];
    end
  end
endmodule

// File: dv/dmt_checker.sv
// port checker for the dual mode timer
// assumes a bind onto the timer top and one clock domain
module dmt_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standby,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic [7:0] rdata,
  input wire logic upper_toggle_output_pin,
  input wire logic lower_toggle_output_pin,
  input wire logic upper_overflow_irq,
  input wire logic lower_overflow_irq,
  input wire logic upper_compare_irq,
  input wire logic lower_compare_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // *****
  // checks
  // *****
  wire stat_w = wr && addr == 16'hffb7;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence ctrl_wr;
    wr && addr == 16'hffb6;
  endsequence
  sequence stat_zero(int b);
    stat_w ##0 !wdata[b];
  endsequence
  ltog_level_a: assert property (
    ctrl_wr |=> lower_toggle_output_pin == $past(wdata[3]))
    else $error("lower toggle level wrong");
  utog_level_a: assert property (
    ctrl_wr |=> upper_toggle_output_pin == $past(wdata[7]))
    else $error("upper toggle level wrong");
  uovie_gate_a: assert property (
    stat_zero(5) |=> ##1 !upper_overflow_irq)
    else $error("upper overflow irq while disabled");
  lovie_gate_a: assert property (
    stat_zero(1) |=> ##1 !lower_overflow_irq)
    else $error("lower overflow irq while disabled");
  ucmf_hold_a: assert property (
    $fell(upper_compare_irq) |-> $past(stat_w, 2) || $past(standby, 2))
    else $error("upper compare flag dropped");
  lcmf_hold_a: assert property (
    $fell(lower_compare_irq) |-> $past(stat_w, 2) || $past(standby, 2))
    else $error("lower compare flag dropped");
  standby_clr_a: assert property (
    standby [*3] |-> !upper_compare_irq && !lower_compare_irq)
    else $error("flags kept in standby");
  // control register is write-only, so it reads all ones
  ctrl_read_a: assert property (
    $past(addr) == 16'hffb6 |-> rdata == 8'hff)
    else $error("control register readable");
endmodule

// File: dv/dmt_cpu.sv
// cpu side model: byte writes and reads on the peripheral bus
// assumes strobes are sampled on rising clock edges
module dmt_cpu (
  input wire logic clk,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // *****
  // bus cycles
  // *****
  // strobes held low from time zero, so no stray write
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // released lines flip so stale values cannot pass for good ones
  task automatic put(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask
  // a flag clear is only tried after this read has seen it
  task automatic get(input logic [15:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    v = rdata;
    rd = 1'b0;
    addr = ~a;
  endtask
endmodule

// File: dv/tb_dual_mode_compare_timer_ctrl.sv
// bench for the dual mode timer: cpu model plus event pin stimulus
// assumes the checker bound at the foot and a 20 MHz clock
module tb_dual_mode_compare_timer_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic standby = 1'b0;
  logic ev = 1'b0;
  logic ev_sel = 1'b1;
  logic wr, rd, utog, ltog, uov, lov, ucm, lcm;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, d;
  int num_errors = 0;
  int comparisons = 0;
  int dv[4] = '{32, 16, 4, 2};
  always #25 clk = ~clk;
  dmt_cpu cpu (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  dmt_timer dut (.clk(clk), .rst_n(rst_n), .standby(standby),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .event_input_pin(ev), .event_edge_select(ev_sel),
    .upper_toggle_output_pin(utog), .lower_toggle_output_pin(ltog),
    .upper_overflow_irq(uov), .lower_overflow_irq(lov),
    .upper_compare_irq(ucm), .lower_compare_irq(lcm));
  // *****
  // helpers
  // *****
  task automatic conclude();
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, lo, hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  // low picks the lower overflow request, else the upper one
  task automatic wait_hi(input bit low, input int n);
    for (int i = 0; i < n && (low ? lov : uov) !== 1'b1; i++)
      @(negedge clk);
    if ((low ? lov : uov) !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  // *****
  // scenarios
  // *****
  task automatic reset_vals();
    cpu.get(16'hffb7, d);
    chk(d, 8'h00, 8'h00);
    cpu.get(16'hffbb, d);
    chk(d, 8'hff, 8'hff);
    chk({utog, ltog}, 8'h00, 8'h00);
  endtask
  task automatic levels();
    cpu.put(16'hffb6, 8'h88);
    chk({utog, ltog}, 8'h03, 8'h03);
    cpu.put(16'hffb6, 8'h08);
    chk({utog, ltog}, 8'h01, 8'h01);
  endtask
  // read 130 cycles after each write; prescaler phase costs one tick
  task automatic rates();
    logic [7:0] e;
    for (int s = 0; s < 4; s++) begin
      e = 8'(130 / dv[s]);
      cpu.put(16'hffb6, 8'(8'h44 + s * 17));
      cpu.put(16'hffb8, 8'h00);
      cpu.put(16'hffb9, 8'h00);
      repeat (126) @(negedge clk);
      cpu.get(16'hffb8, d);
      chk(d, e - 8'h01, e + 8'h01);
      cpu.get(16'hffb9, d);
      chk(d, e - 8'h01, e + 8'h01);
    end
  endtask
  task automatic cascade();
    cpu.put(16'hffb6, 8'h37);
    cpu.put(16'hffb7, 8'h20);
    cpu.put(16'hffb8, 8'hff);
    cpu.put(16'hffb9, 8'hf0);
    wait_hi(1'b0, 100);
    cpu.get(16'hffb8, d);
    chk(d, 8'h00, 8'h00);
    cpu.get(16'hffb7, d);
    chk(d, 8'he0, 8'he0);
    cpu.put(16'hffb7, 8'he0);
    cpu.put(16'hffb7, 8'h20);
    cpu.get(16'hffb7, d);
    chk(d, 8'he0, 8'he0);
    cpu.put(16'hffb7, 8'h20);
    cpu.get(16'hffb7, d);
    chk(d, 8'h20, 8'h20);
  endtask
  task automatic eight_bit();
    cpu.put(16'hffb6, 8'h77);
    cpu.put(16'hffb8, 8'h00);
    cpu.put(16'hffb7, 8'h02);
    cpu.put(16'hffb9, 8'hf8);
    wait_hi(1'b1, 40);
    cpu.get(16'hffb7, d);
    chk(d, 8'h0e, 8'h0e);
    cpu.put(16'hffba, 8'h03);
    cpu.put(16'hffbb, 8'h05);
    cpu.put(16'hffb7, 8'h11);
    cpu.put(16'hffb8, 8'h00);
    cpu.put(16'hffb9, 8'h00);
    repeat (40) @(negedge clk);
    cpu.get(16'hffb8, d);
    chk(d, 8'h00, 8'h03);
    cpu.get(16'hffb9, d);
    chk(d, 8'h00, 8'h05);
    cpu.get(16'hffb7, d);
    chk(d, 8'h55, 8'h55);
  endtask
  task automatic standby_clear();
    cpu.put(16'hffb6, 8'h00);
    standby = 1'b1;
    repeat (4) @(negedge clk);
    standby = 1'b0;
    cpu.get(16'hffb7, d);
    chk(d, 8'h00, 8'h00);
  endtask
  // 16-bit mode: a wide match restarts both halves, lower flags stay 0
  task automatic wide_clear();
    cpu.put(16'hffb6, 8'h37);
    cpu.put(16'hffba, 8'h00);
    cpu.put(16'hffbb, 8'h05);
    cpu.put(16'hffb7, 8'h10);
    cpu.put(16'hffb8, 8'h00);
    cpu.put(16'hffb9, 8'h00);
    repeat (40) @(negedge clk);
    cpu.get(16'hffb9, d);
    chk(d, 8'h00, 8'h05);
    cpu.get(16'hffb8, d);
    chk(d, 8'h00, 8'h00);
    cpu.get(16'hffb7, d);
    chk(d, 8'h50, 8'h50);
  endtask
  task automatic events();
    cpu.put(16'hffb6, 8'h43);
    for (int e = 1; e >= 0; e--) begin
      ev_sel = e[0];
      cpu.put(16'hffb9, 8'h00);
      repeat (6) begin
        repeat (4) @(negedge clk);
        ev = ~ev;
      end
      cpu.get(16'hffb9, d);
      chk(d, 8'h03, 8'h03);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    reset_vals();
    levels();
    rates();
    cascade();
    eight_bit();
    standby_clear();
    wide_clear();
    events();
    conclude();
  end
endmodule
bind dmt_timer dmt_checker chk_i (.clk(clk), .rst_n(rst_n),
  .standby(standby), .addr(addr), .wdata(wdata), .wr(wr), .rdata(rdata),
  .upper_toggle_output_pin(upper_toggle_output_pin),
  .lower_toggle_output_pin(lower_toggle_output_pin),
  .upper_overflow_irq(upper_overflow_irq),
  .lower_overflow_irq(lower_overflow_irq),
  .upper_compare_irq(upper_compare_irq),
  .lower_compare_irq(lower_compare_irq));

// File: include/dmt_defines.vh
// constants for the dual mode compare timer control block
// assumes an 8-bit peripheral bus with byte addresses
`ifndef DMT_DEFINES_VH
`define DMT_DEFINES_VH
`define DMT_ADDR_CTRL 16'hffb6
`define DMT_ADDR_CSR 16'hffb7
`define DMT_ADDR_UCNT 16'hffb8
`define DMT_ADDR_LCNT 16'hffb9
`define DMT_ADDR_UCMP 16'hffba
`define DMT_ADDR_LCMP 16'hffbb
`define DMT_BYTE_ZERO 8'h00
`define DMT_BYTE_ONES 8'hff
`define DMT_CMP_RESET 8'hff
`define DMT_CSR_RESET 8'h00
`define DMT_CTRL_RESET 8'h00
`define DMT_B_UTOG 7
`define DMT_B_USEL_TOP 6
`define DMT_B_USEL_MID 5
`define DMT_B_USEL_LOW 4
`define DMT_B_LTOG 3
`define DMT_B_LSEL_TOP 2
`define DMT_B_LSEL_MID 1
`define DMT_B_LSEL_LOW 0
`define DMT_B_UOVF 7
`define DMT_B_UCMF 6
`define DMT_B_UOVIE 5
`define DMT_B_UCLR 4
`define DMT_B_LOVF 3
`define DMT_B_LCMF 2
`define DMT_B_LOVIE 1
`define DMT_B_LCLR 0
`define DMT_PRE_W 5
`define DMT_PRE_ONE 5'h01
`define DMT_SEL_D32 2'h0
`define DMT_SEL_D16 2'h1
`define DMT_SEL_D4 2'h2
`define DMT_SEL_D2 2'h3
`define DMT_TAP_D32 4
`define DMT_TAP_D16 3
`define DMT_TAP_D4 1
`define DMT_TAP_D2 0
`endif
